// [src/voice_cmd_decoder.v]
`timescale 1ns/10ps
`include "cmd_decoder_defs.vh"

module voice_cmd_decoder #(
   parameter [21:0] WAKE_CYCLES = `WAKE_COUNT,
   parameter [24:0] ROW_CYCLES  = `ROW_COUNT
) (
   // Clock and reset
   input  wire        SYS_CLK,
   input  wire        RST,
   // Serial link from the host
   input  wire        SCLK,
   input  wire        SS_N,
   input  wire        MOSI,
   output wire        MISO_O,
   output wire        MISO_OE,
   // Interrupt, open drain
   output wire        INT_O,
   output wire        INT_OE,
   // Array side
   input  wire        ROW_MARK,
   output wire        ROW_TICK,
   output wire [15:0] ROW_PTR,
   // Operation status
   output wire        POWERED,
   output wire        READY,
   output wire        PLAYING,
   output wire        RECORDING,
   output wire        CUEING
);

   // ----------------------------------------
   // Local constants
   // ----------------------------------------
   localparam [1:0]  ST_IDLE = 2'h0;
   localparam [1:0]  ST_PLAY = 2'h1;
   localparam [1:0]  ST_REC  = 2'h2;
   localparam [1:0]  ST_CUE  = 2'h3;
   // Row time must stay at or above the speed-up, or CUE_CYCLES is zero and cue rows wrap to the full counter length
   localparam [24:0] CUE_CYCLES = ROW_CYCLES / `CUE_SPEEDUP;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   function [3:0] decode_cmd;
      input [4:0] c;
      reg   [4:0] p;
      begin
         p = {c[0], c[1], c[2], c[3], c[4]};
         casez (p)
            5'b?10?0: decode_cmd = `CMD_SLEEP;
            5'b011?0: decode_cmd = `CMD_HALT;
            5'b00100: decode_cmd = `CMD_WAKE;
            5'b00111: decode_cmd = `CMD_LISTEN_GIVEN;
            5'b01111: decode_cmd = `CMD_LISTEN_CUR;
            5'b00101: decode_cmd = `CMD_CAPT_GIVEN;
            5'b01101: decode_cmd = `CMD_CAPT_CUR;
            5'b10111: decode_cmd = `CMD_CUE_GIVEN;
            5'b11111: decode_cmd = `CMD_CUE_SKIP;
            default:  decode_cmd = `CMD_NONE;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg        sclk_s1_r, sclk_s2_r, sclk_s3_r;
   reg        ss_s1_r, ss_s2_r, ss_s3_r;
   reg        mosi_s1_r, mosi_s2_r;
   reg [23:0] in_sh_r, in_sh_nxt;
   reg [17:0] out_sh_r, out_sh_nxt;
   reg [4:0]  bit_cnt_r, bit_cnt_nxt;
   reg        miso_r, miso_nxt;
   reg        miso_oe_r, miso_oe_nxt;
   reg        int_r, int_nxt;
   reg        ovf_r, ovf_nxt;
   reg        eom_r, eom_nxt;
   reg [1:0]  state_r, state_nxt;
   reg [15:0] ptr_r, ptr_nxt;
   reg        repeat_r, repeat_nxt;
   reg [24:0] row_cnt_r, row_cnt_nxt;
   reg        tick_r, tick_nxt;
   reg        powered_r, powered_nxt;
   reg [21:0] wake_cnt_r, wake_cnt_nxt;
   reg        ready_r, ready_nxt;
   reg        playing_r;
   reg        recording_r;
   reg        cueing_r;

   // ----------------------------------------
   // Edge detection on synchronised pins
   // ----------------------------------------
   wire       sclk_rise = sclk_s2_r & ~sclk_s3_r;
   wire       sclk_fall = ~sclk_s2_r & sclk_s3_r;
   wire       ss_fall   = ~ss_s2_r & ss_s3_r;
   wire       ss_rise   = ss_s2_r & ~ss_s3_r;
   wire       in_frame  = ~ss_s2_r;
   wire [3:0] cmd       = decode_cmd(in_sh_r[`C4_POS:`C0_POS]);
   wire       frame_ok  = ss_rise && (bit_cnt_r == `FRAME_BITS);
   wire       row_end   = (state_r != ST_IDLE) && (row_cnt_r == 25'h0000000);
   wire       last_row  = (ptr_r == `LAST_ROW);

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always @* begin
      in_sh_nxt    = in_sh_r;
      out_sh_nxt   = out_sh_r;
      bit_cnt_nxt  = bit_cnt_r;
      miso_nxt     = miso_r;
      miso_oe_nxt  = in_frame;
      int_nxt      = int_r;
      ovf_nxt      = ovf_r;
      eom_nxt      = eom_r;
      state_nxt    = state_r;
      ptr_nxt      = ptr_r;
      repeat_nxt   = repeat_r;
      row_cnt_nxt  = row_cnt_r;
      tick_nxt     = 1'b0;
      powered_nxt  = powered_r;
      wake_cnt_nxt = wake_cnt_r;
      ready_nxt    = ready_r;

      // Serial shifting
      if (ss_fall) begin
         // Snapshot status, then clear; events in this cycle are set below
         out_sh_nxt  = {ptr_r, eom_r, ovf_r};
         miso_nxt    = ovf_r;
         bit_cnt_nxt = 5'h00;
         int_nxt     = 1'b0;
         ovf_nxt     = 1'b0;
         eom_nxt     = 1'b0;
      end else if (in_frame) begin
         if (sclk_rise) begin
            in_sh_nxt = {mosi_s2_r, in_sh_r[23:1]};
            if (bit_cnt_r != 5'h1F)
               bit_cnt_nxt = bit_cnt_r + 5'h01;
         end
         if (sclk_fall) begin
            out_sh_nxt = {1'b0, out_sh_r[17:1]};
            miso_nxt   = out_sh_r[1];
         end
      end

      // Wake delay
      if (wake_cnt_r != 22'h000000)
         wake_cnt_nxt = wake_cnt_r - 22'h000001;
      // Ready is power plus an expired delay count
      ready_nxt = powered_r && (wake_cnt_r == 22'h000000);

      // Row timing and automatic stops
      if (state_r != ST_IDLE) begin
         if (row_end) begin
            tick_nxt    = 1'b1;
            row_cnt_nxt = (state_r == ST_CUE) ? CUE_CYCLES - 25'h0000001
                                              : ROW_CYCLES - 25'h0000001;
            case (state_r)
               ST_PLAY: begin
                  if (ROW_MARK) begin
                     eom_nxt = 1'b1;
                     int_nxt = 1'b1;
                     state_nxt = ST_IDLE;
                  end else if (last_row) begin
                     ovf_nxt = 1'b1;
                     int_nxt = 1'b1;
                     state_nxt = ST_IDLE;
                  end else if (!repeat_r)
                     ptr_nxt = ptr_r + 16'h0001;
               end
               ST_REC: begin
                  if (last_row) begin
                     ovf_nxt = 1'b1;
                     int_nxt = 1'b1;
                     state_nxt = ST_IDLE;
                  end else if (!repeat_r)
                     ptr_nxt = ptr_r + 16'h0001;
               end
               ST_CUE: begin
                  if (last_row) begin
                     ovf_nxt = 1'b1;
                     int_nxt = 1'b1;
                     state_nxt = ST_IDLE;
                  end else begin
                     ptr_nxt = ptr_r + 16'h0001;
                     if (ROW_MARK) begin
                        eom_nxt = 1'b1;
                        int_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                     end
                  end
               end
               default: state_nxt = ST_IDLE;
            endcase
         end else
            row_cnt_nxt = row_cnt_r - 25'h0000001;
      end

      // Commands act only after select rises on a whole frame
      if (frame_ok) begin
         case (cmd)
            `CMD_WAKE: begin
               powered_nxt  = 1'b1;
               wake_cnt_nxt = WAKE_CYCLES;
               ready_nxt    = 1'b0;
            end
            `CMD_SLEEP: begin
               state_nxt   = ST_IDLE;
               powered_nxt = 1'b0;
               ready_nxt   = 1'b0;
               wake_cnt_nxt = 22'h000000;
            end
            `CMD_HALT: state_nxt = ST_IDLE;
            `CMD_LISTEN_GIVEN, `CMD_LISTEN_CUR,
            `CMD_CAPT_GIVEN, `CMD_CAPT_CUR,
            `CMD_CUE_GIVEN, `CMD_CUE_SKIP: begin
               // Cueing cannot be switched on over a running playback
               if (ready_r && !(in_sh_r[`C0_POS] && state_r == ST_PLAY)) begin
                  if (in_sh_r[`C0_POS])
                     state_nxt = ST_CUE;
                  else if (in_sh_r[`C3_POS])
                     state_nxt = ST_PLAY;
                  else
                     state_nxt = ST_REC;
                  if (!in_sh_r[`C1_POS]) begin
                     ptr_nxt     = in_sh_r[15:`ADDR_LSB];
                     repeat_nxt  = !in_sh_r[`C0_POS];
                     row_cnt_nxt = in_sh_r[`C0_POS] ? CUE_CYCLES - 25'h0000001
                                                    : ROW_CYCLES - 25'h0000001;
                  end else begin
                     repeat_nxt = 1'b0;
                     if (state_r == ST_IDLE)
                        row_cnt_nxt = in_sh_r[`C0_POS] ? CUE_CYCLES - 25'h0000001
                                                       : ROW_CYCLES - 25'h0000001;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // State registers
   // ----------------------------------------
   always @(posedge SYS_CLK) begin
      // Only the second and third stages feed logic, so metastability stays contained
      sclk_s1_r <= SCLK;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      ss_s1_r   <= SS_N;
      ss_s2_r   <= ss_s1_r;
      ss_s3_r   <= ss_s2_r;
      mosi_s1_r <= MOSI;
      mosi_s2_r <= mosi_s1_r;
      if (RST) begin
         in_sh_r    <= 24'h000000;
         out_sh_r   <= 18'h00000;
         bit_cnt_r  <= 5'h00;
         miso_r     <= 1'b0;
         miso_oe_r  <= 1'b0;
         int_r      <= 1'b0;
         ovf_r      <= 1'b0;
         eom_r      <= 1'b0;
         state_r    <= ST_IDLE;
         ptr_r      <= `PTR_RESET;
         repeat_r   <= 1'b0;
         row_cnt_r  <= 25'h0000000;
         tick_r     <= 1'b0;
         powered_r  <= 1'b0;
         wake_cnt_r <= 22'h000000;
         ready_r    <= 1'b0;
         playing_r   <= 1'b0;
         recording_r <= 1'b0;
         cueing_r    <= 1'b0;
      end else begin
         in_sh_r    <= in_sh_nxt;
         out_sh_r   <= out_sh_nxt;
         bit_cnt_r  <= bit_cnt_nxt;
         miso_r     <= miso_nxt;
         miso_oe_r  <= miso_oe_nxt;
         int_r      <= int_nxt;
         ovf_r      <= ovf_nxt;
         eom_r      <= eom_nxt;
         state_r    <= state_nxt;
         ptr_r      <= ptr_nxt;
         repeat_r   <= repeat_nxt;
         row_cnt_r  <= row_cnt_nxt;
         tick_r     <= tick_nxt;
         powered_r  <= powered_nxt;
         wake_cnt_r <= wake_cnt_nxt;
         ready_r    <= ready_nxt;
         // Status decoded from the next state so the pins never glitch
         playing_r   <= (state_nxt == ST_PLAY);
         recording_r <= (state_nxt == ST_REC);
         cueing_r    <= (state_nxt == ST_CUE);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign MISO_O    = miso_r;
   assign MISO_OE   = miso_oe_r;
   // Open drain: the pin only pulls low, so the enable carries the event
   assign INT_O     = 1'b0;
   assign INT_OE    = int_r;
   assign ROW_TICK  = tick_r;
   assign ROW_PTR   = ptr_r;
   assign POWERED   = powered_r;
   assign READY     = ready_r;
   assign PLAYING   = playing_r;
   assign RECORDING = recording_r;
   assign CUEING    = cueing_r;

endmodule // voice_cmd_decoder

// [src/cmd_decoder_defs.vh]
`ifndef CMD_DECODER_DEFS_VH
`define CMD_DECODER_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_MHZ          100
`define WAKE_DELAY_US    25000
`define ROW_TIME_US      200000
`define CUE_SPEEDUP      25'h0000640
`define WAKE_COUNT       22'h2625A0
`define ROW_COUNT        25'h1312D00

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define FRAME_BITS       5'h18
`define ADDR_LSB         0
`define C0_POS           16
`define C1_POS           17
`define C2_POS           18
`define C3_POS           19
`define C4_POS           20
`define OUT_OVF_POS      0
`define OUT_EOM_POS      1
`define OUT_PTR_LSB      2

// ----------------------------------------
// Memory geometry and reset values
// ----------------------------------------
`define LAST_ROW         16'h095F
`define PTR_RESET        16'h0000

// ----------------------------------------
// Decoded commands
// ----------------------------------------
`define CMD_NONE         4'h0
`define CMD_WAKE         4'h1
`define CMD_LISTEN_GIVEN 4'h2
`define CMD_LISTEN_CUR   4'h3
`define CMD_CAPT_GIVEN   4'h4
`define CMD_CAPT_CUR     4'h5
`define CMD_CUE_GIVEN    4'h6
`define CMD_CUE_SKIP     4'h7
`define CMD_HALT         4'h8
`define CMD_SLEEP        4'h9

`endif

// [test/voice_cmd_decoder_chk.sv]
`timescale 1ns/10ps
module voice_cmd_decoder_chk (
   // Clock and reset
   input wire        SYS_CLK,
   input wire        RST,
   // Serial link and interrupt
   input wire        SCLK,
   input wire        SS_N,
   input wire        MOSI,
   input wire        MISO_O,
   input wire        MISO_OE,
   input wire        INT_O,
   input wire        INT_OE,
   // Array side and status
   input wire        ROW_MARK,
   input wire        ROW_TICK,
   input wire [15:0] ROW_PTR,
   input wire        POWERED,
   input wire        READY,
   input wire        PLAYING,
   input wire        RECORDING,
   input wire        CUEING
);
   wire busy;
   assign busy = PLAYING | RECORDING | CUEING;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   chk_int_clear: assert property ($fell(SS_N) |-> ##[1:5] !INT_OE)
      else $error("interrupt still pending after transfer start");
   chk_oe_on: assert property ($fell(SS_N) |-> ##[2:4] MISO_OE)
      else $error("serial output not enabled after select");
   chk_oe_off: assert property (SS_N [*5] |-> !MISO_OE)
      else $error("serial output driven while deselected");
   chk_late_cmd: assert property (!SS_N |=> $stable(POWERED))
      else $error("power state changed inside a transfer");
   chk_ready_pwr: assert property (READY |-> POWERED)
      else $error("ready while not powered");
   chk_one_op: assert property ($onehot0({PLAYING, RECORDING, CUEING}))
      else $error("two operations at once");
   chk_start_ready: assert property ($rose(busy) |-> $past(READY))
      else $error("operation started before ready");
   chk_tick_run: assert property (ROW_TICK |-> $past(busy))
      else $error("row tick without an operation");
   chk_tick_pulse: assert property (ROW_TICK |=> !ROW_TICK)
      else $error("row tick longer than one cycle");
   chk_mark_end: assert property (ROW_TICK && ROW_MARK && $past(PLAYING | CUEING)
      |-> ##[0:2] (INT_OE && !busy))
      else $error("no stop and interrupt at message end");
   chk_int_low: assert property ($rose(INT_OE) |-> !busy && $past(busy) && !INT_O)
      else $error("interrupt raised without an operation ending");

   // Main scenarios reached
   cover property ($rose(RECORDING));
   cover property ($rose(CUEING));
   cover property ($rose(INT_OE));
   cover property ($rose(READY));
endmodule // voice_cmd_decoder_chk

// [test/spi_host_model.sv]
`timescale 1ns/10ps
module spi_host_model (
   // Link toward the device
   output reg  SCLK,
   output reg  SS_N,
   output reg  MOSI,
   input  wire MISO_O,
   input  wire MISO_OE
);
   initial begin
      SCLK = 1'b0;
      SS_N = 1'b1;
      MOSI = 1'b1;
   end

   // Whole 24-bit frame; clock stands still between frames
   task xfer(input [23:0] tx, output [23:0] rx);
      integer i;
      begin
         SS_N = 1'b0;
         // Odd offset keeps link edges clear of system clock edges
         #63.5;
         for (i = 0; i < 24; i = i + 1) begin
            MOSI = tx[i];
            #62.5 SCLK = 1'b1;
            rx[i] = MISO_OE ? MISO_O : 1'bx;
            #62.5 SCLK = 1'b0;
         end
         #62.5 SS_N = 1'b1;
         // Released line must not keep showing the last bit
         MOSI = ~MOSI;
         #100;
      end
   endtask
endmodule // spi_host_model

// [test/testbench.sv]
`timescale 1ns/10ps
module testbench;
   reg         SYS_CLK = 1'b0;
   reg         RST = 1'b1;
   reg         ROW_MARK = 1'b0;
   wire        SCLK, SS_N, MOSI, MISO_O, MISO_OE, INT_O, INT_OE, ROW_TICK;
   wire        POWERED, READY, PLAYING, RECORDING, CUEING;
   wire [15:0] ROW_PTR;
   wire [5:0]  st = {POWERED, READY, PLAYING, RECORDING, CUEING, INT_OE};
   reg  [23:0] rx;
   reg  [15:0] p;
   integer     errors = 0;
   integer     comparisons = 0;
   // Control digits C0..C4, left to right
   localparam [0:4] k_wake = 5'h04, k_listen_row = 5'h07, k_listen = 5'h0F;
   localparam [0:4] k_capt_row = 5'h05, k_capt = 5'h0D, k_cue_row = 5'h17;
   localparam [0:4] k_cue_skip = 5'h1F, k_halt = 5'h0C, k_halt_c3 = 5'h0E;
   localparam [0:4] k_sleep = 5'h1A, k_unlisted = 5'h06;

   always #5 SYS_CLK = ~SYS_CLK;

   // Short counts keep the run brief
   voice_cmd_decoder #(.WAKE_CYCLES(22'h000032), .ROW_CYCLES(25'h0000C80)) DUT (
      .SYS_CLK(SYS_CLK), .RST(RST), .SCLK(SCLK), .SS_N(SS_N), .MOSI(MOSI),
      .MISO_O(MISO_O), .MISO_OE(MISO_OE), .INT_O(INT_O), .INT_OE(INT_OE),
      .ROW_MARK(ROW_MARK), .ROW_TICK(ROW_TICK), .ROW_PTR(ROW_PTR), .POWERED(POWERED),
      .READY(READY), .PLAYING(PLAYING), .RECORDING(RECORDING), .CUEING(CUEING));
   spi_host_model host (.SCLK(SCLK), .SS_N(SS_N), .MOSI(MOSI), .MISO_O(MISO_O),
      .MISO_OE(MISO_OE));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task chk(input [23:0] got, input [23:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chks(input [5:0] e);
      chk({18'h00000, st}, {18'h00000, e});
   endtask
   task chkp(input [15:0] e);
      chk({8'h00, ROW_PTR}, {8'h00, e});
   endtask
   task send(input [0:4] c, input [15:0] a);
      begin
         @(negedge SYS_CLK);
         host.xfer({3'h0, c[4], c[3], c[2], c[1], c[0], a}, rx);
      end
   endtask
   task wtick;
      integer n;
      begin
         n = 0;
         @(negedge SYS_CLK);
         while (ROW_TICK !== 1'b1 && n < 5000) begin
            @(negedge SYS_CLK);
            n = n + 1;
         end
         if (n == 5000) errors = errors + 1;
         @(negedge SYS_CLK);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_wake;
      begin
         chks(6'h00);
         chkp(16'h0000);
         send(k_listen_row, 16'h0010);
         chks(6'h00);
         send(k_wake, 16'hFFFF);
         chks(6'h20);
         repeat (50) @(negedge SYS_CLK);
         chks(6'h30);
      end
   endtask
   task t_listen;
      begin
         send(k_listen_row, 16'h0010);
         chks(6'h38);
         chkp(16'h0010);
         wtick;
         chkp(16'h0010);
         send(k_listen, 16'hFFFF);
         chkp(16'h0010);
         wtick;
         chkp(16'h0011);
         ROW_MARK = 1'b1;
         wtick;
         repeat (3) @(negedge SYS_CLK);
         chks(6'h31);
         p = ROW_PTR;
         send(k_halt, 16'h0000);
         chk(rx, {6'h00, p, 2'h2});
         chks(6'h30);
      end
   endtask
   task t_capture;
      begin
         ROW_MARK = 1'b0;
         send(k_wake, 16'h0000);
         repeat (50) @(negedge SYS_CLK);
         send(k_wake, 16'h0000);
         repeat (100) @(negedge SYS_CLK);
         send(k_capt_row, 16'h095E);
         chks(6'h34);
         send(k_capt, 16'h0000);
         wtick;
         chkp(16'h095F);
         wtick;
         repeat (3) @(negedge SYS_CLK);
         chks(6'h31);
         send(k_halt, 16'h0000);
         chk({22'h000000, rx[1:0]}, 24'h000001);
      end
   endtask
   task t_cue;
      begin
         ROW_MARK = 1'b1;
         send(k_cue_row, 16'h0020);
         chks(6'h31);
         chkp(16'h0021);
         send(k_cue_skip, 16'h0000);
         chk(rx, {6'h00, 16'h0021, 2'h2});
         chkp(16'h0022);
         send(k_listen_row, 16'h0030);
         send(k_cue_skip, 16'h0000);
         chks(6'h38);
         chkp(16'h0030);
      end
   endtask
   task t_halt;
      begin
         send(k_unlisted, 16'h0000);
         chks(6'h38);
         chkp(16'h0030);
         send(k_halt_c3, 16'h0000);
         chks(6'h30);
         send(k_listen_row, 16'h0040);
         send(k_halt, 16'h0000);
         chks(6'h30);
         send(k_sleep, 16'h0000);
         chks(6'h00);
         send(k_listen_row, 16'h0050);
         chks(6'h00);
      end
   endtask

   task end_of_test;
      begin
         $display("errors %0d comparisons %0d", errors, comparisons);
         if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   initial begin
      repeat (5) @(negedge SYS_CLK);
      RST = 1'b0;
      @(negedge SYS_CLK);
      t_wake;
      t_listen;
      t_capture;
      t_cue;
      t_halt;
      end_of_test;
   end
   // Whole run needs about 220 us
   initial begin
      #900000;
      errors = errors + 1;
      end_of_test;
   end
endmodule // testbench

bind voice_cmd_decoder voice_cmd_decoder_chk u_chk (
   .SYS_CLK(SYS_CLK), .RST(RST), .SCLK(SCLK), .SS_N(SS_N), .MOSI(MOSI), .MISO_O(MISO_O),
   .MISO_OE(MISO_OE), .INT_O(INT_O), .INT_OE(INT_OE), .ROW_MARK(ROW_MARK),
   .ROW_TICK(ROW_TICK), .ROW_PTR(ROW_PTR), .POWERED(POWERED), .READY(READY),
   .PLAYING(PLAYING), .RECORDING(RECORDING), .CUEING(CUEING));
